// ---- scmc_pkg.sv ----
// scmc_pkg: register map, field layout, reset values and codes of the serial channel mode block
// assumes a 32-bit apb slave at 10 mhz; offsets are word aligned byte addresses
package scmc_pkg;
   // register byte addresses
   localparam logic [7:0] OFS_ASYNC_FRAMING = 8'h00;
   localparam logic [7:0] OFS_LINE_CODE = 8'h04;
   localparam logic [7:0] OFS_PROTOCOL = 8'h08;
   localparam logic [7:0] OFS_CHANNEL_CMD = 8'h0c;
   localparam logic [7:0] OFS_DECODED = 8'h10;
   // reset values
   localparam logic [7:0] RST_ASYNC_FRAMING = 8'h00;
   localparam logic [7:0] RST_LINE_CODE = 8'h00;
   localparam logic [2:0] RST_PROTOCOL = 3'h0;
   // async_framing_mode field positions (low bit)
   localparam int POS_OVERSAMPLE = 6;
   localparam int POS_TX_CHAR = 4;
   localparam int POS_RX_CHAR = 2;
   localparam int POS_PARITY = 0;
   // line_code_mode field positions
   localparam int POS_FAMILY = 7;
   localparam int POS_VARIANT = 5;
   localparam int POS_PLL_RATIO = 3;
   localparam int POS_CONNECT = 0;
   // channel command word: bit 0 requests a channel reset
   localparam int POS_CHAN_RESET = 0;
   // protocol codes
   localparam logic [2:0] PROTO_ASYNC = 3'h0;
   localparam logic [2:0] PROTO_BITSYNC = 3'h4;
   // channel connection codes
   localparam logic [1:0] CONN_NORMAL = 2'h0;
   localparam logic [1:0] CONN_ECHO = 2'h1;
   localparam logic [1:0] CONN_LOOP = 2'h3;
   // oversample divisors as log2
   localparam logic [2:0] OVS_LOG2_1 = 3'h0;
   localparam logic [2:0] OVS_LOG2_16 = 3'h4;
   localparam logic [2:0] OVS_LOG2_32 = 3'h5;
   localparam logic [2:0] OVS_LOG2_64 = 3'h6;
   // pll ratios
   localparam logic [5:0] PLL_X8 = 6'h08;
   localparam logic [5:0] PLL_X16 = 6'h10;
   localparam logic [5:0] PLL_X32 = 6'h20;
   // character length base: code 00 gives 8 bits
   localparam logic [3:0] CHAR_LEN_MAX = 4'h8;
   // line code kinds
   typedef enum logic [2:0]
   {
      SCMC_CODE_NRZ = 3'b000,
      SCMC_CODE_NRZI = 3'b001,
      SCMC_CODE_MANCH = 3'b010,
      SCMC_CODE_FM1 = 3'b011,
      SCMC_CODE_FM0 = 3'b100,
      SCMC_CODE_RSVD = 3'b111
   } scmc_code_t;
endpackage

// ---- scmc_mode_config.sv ----
// scmc_mode_config: two mode registers of a serial channel, apb slave, decoded controls and line routing
// assumes shifters supply character boundary pulses; clocks and data lines are sampled pin levels
// Overview of operation
// - hardware reset or channel reset command returns both mode registers to reset
// - async oversample codes 00..11 give bit rate clock/1, /16, /32, /64
// - bits 7-6 apply to transmitter and receiver together
// - bit-sync address check: none, single 1, single 2, dual
// - async transmit length codes 00..11 give 8, 7, 6, 5 bits
// - new transmit length takes effect from next transmitted character
// - receive length uses same mapping; change applies from next received character
// - parity selector: none, multidrop bit, even parity, odd parity
// - parity selector change governs only characters after the write
// - first register idle in byte-sync; reserved fields read zero, software writes zero
// - code family: 0 NRZ, 1 FM in sync modes; reads zero in async
// - NRZ family: 00 NRZ, 01 NRZI, others reserved
// - FM family: 00 Manchester, 01 FM1, 10 FM0, 11 reserved
// - sync pll ratio codes 00..10 give x8, x16, x32; 11 reserved
// - connection 00 normal full duplex; 10 reserved
// - auto-echo copies serial input to output; receive on, transmit off
// - echo or loopback drives receive clock onto transmit clock line when output
// - loopback feeds transmit shifter into receive shifter, both clocked by receive clock
// - loopback also echoes serial input to serial output
// - pll clock chosen in loopback drives both transmitter and receiver
// - protocol selector: 000 async, 001-011 byte-sync, 100 bit-sync, rest reserved
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module scmc_mode_config
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_char_start,
   input wire logic rx_char_start,
   input wire logic tx_clock_line_is_output,
   input wire logic rx_clock_is_pll,
   input wire logic serial_in,
   input wire logic rx_clock_in,
   input wire logic pll_clock_in,
   input wire logic pll_data_in,
   input wire logic noise_supp_sel,
   input wire logic tx_shift_out,
   output logic [2:0] oversample_log2,
   output logic [1:0] frame_addr_check_sel,
   output logic [3:0] tx_char_bits,
   output logic [3:0] rx_char_bits,
   output logic [1:0] tx_parity_sel,
   output logic [1:0] rx_parity_sel,
   output logic [2:0] line_code,
   output logic [5:0] pll_clock_ratio,
   output logic tx_enable,
   output logic rx_data_out,
   output logic serial_out,
   output logic shift_clock,
   output logic tx_clock_line_out,
   output logic tx_clock_line_oe
);
   // line inputs from other domains, three stages each
   localparam int NSYNC = 5;

   typedef struct packed
   {
      logic [7:0] async_framing_mode;
      logic [7:0] line_code_mode;
      logic [2:0] protocol_sel;
      logic [1:0] tx_char_len;
      logic [1:0] rx_char_len;
      logic [1:0] tx_parity;
      logic [1:0] rx_parity;
      logic [NSYNC-1:0] sync1;
      logic [NSYNC-1:0] sync2;
      logic [NSYNC-1:0] sync3;
      logic [NSYNC-1:0] line;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [2:0] oversample_log2;
      logic [1:0] frame_addr_check_sel;
      logic [3:0] tx_char_bits;
      logic [3:0] rx_char_bits;
      logic [1:0] tx_parity_sel;
      logic [1:0] rx_parity_sel;
      logic [2:0] line_code;
      logic [5:0] pll_clock_ratio;
      logic tx_enable;
      logic rx_data_out;
      logic serial_out;
      logic shift_clock;
      logic tx_clock_line_out;
      logic tx_clock_line_oe;
   } scmc_state_t;

   scmc_state_t st_reg;
   scmc_state_t st_next;

   // masks a written or stored mode byte down to what the protocol defines
   function automatic logic [7:0] mask_framing(input logic [2:0] proto, input logic [7:0] v);
      if (proto == scmc_pkg::PROTO_ASYNC)
         mask_framing = v;
      else if (proto == scmc_pkg::PROTO_BITSYNC)
         mask_framing = {v[7:6], 6'h00};
      else
         mask_framing = 8'h00;
   endfunction

   function automatic logic [7:0] mask_line_code(input logic [2:0] proto, input logic [7:0] v);
      if (proto == scmc_pkg::PROTO_ASYNC)
         mask_line_code = {5'h00, 1'b0, v[1:0]} & 8'h03;
      else
         mask_line_code = {v[7:3], 1'b0, v[1:0]};
   endfunction

   // character length code to bit count: 00 -> 8 down to 11 -> 5
   function automatic logic [3:0] char_bits(input logic [1:0] code);
      char_bits = scmc_pkg::CHAR_LEN_MAX - {2'h0, code};
   endfunction

   logic bus_access;
   logic bus_write;
   logic chan_reset;
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] stable;
   logic [1:0] ovs_code;
   logic [1:0] conn;
   logic in_sync_mode;

   assign bus_access = psel && penable && !st_reg.pready;
   assign bus_write = bus_access && pwrite;
   assign chan_reset = bus_write && (paddr == scmc_pkg::OFS_CHANNEL_CMD) && pwdata[scmc_pkg::POS_CHAN_RESET];
   assign pins = {serial_in, rx_clock_in, pll_clock_in, pll_data_in, tx_shift_out};
   assign ovs_code = st_reg.async_framing_mode[scmc_pkg::POS_OVERSAMPLE +: 2];
   assign conn = st_reg.line_code_mode[scmc_pkg::POS_CONNECT +: 2];
   assign in_sync_mode = st_reg.protocol_sel != scmc_pkg::PROTO_ASYNC;

   // a pin counts as changed only once stages two and three agree; stage one feeds stage two only
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_pin
         assign stable[gi] = (st_reg.sync2[gi] == st_reg.sync3[gi]) ? st_reg.sync3[gi] : st_reg.line[gi];
      end
   endgenerate

   always_comb
   begin
      logic [2:0] fam_var;
      logic sel_data;
      logic sel_clock;
      fam_var = 3'h0;
      sel_data = 1'b0;
      sel_clock = 1'b0;
      st_next = st_reg;
      st_next.sync1 = pins;
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      st_next.line = stable;

      // apb: one wait state, answer in the second access cycle
      st_next.pready = bus_access;
      st_next.pslverr = 1'b0;
      if (bus_access)
      begin
         st_next.prdata = 32'h0000_0000;
         case (paddr)
            scmc_pkg::OFS_ASYNC_FRAMING:
            begin
               if (pwrite)
                  st_next.async_framing_mode = mask_framing(st_reg.protocol_sel, pwdata[7:0]);
               st_next.prdata = {24'h00_0000, st_reg.async_framing_mode};
            end
            scmc_pkg::OFS_LINE_CODE:
            begin
               if (pwrite)
                  st_next.line_code_mode = mask_line_code(st_reg.protocol_sel, pwdata[7:0]);
               st_next.prdata = {24'h00_0000, st_reg.line_code_mode};
            end
            scmc_pkg::OFS_PROTOCOL:
            begin
               if (pwrite)
               begin
                  st_next.protocol_sel = pwdata[2:0];
                  st_next.async_framing_mode = mask_framing(pwdata[2:0], st_reg.async_framing_mode);
                  st_next.line_code_mode = mask_line_code(pwdata[2:0], st_reg.line_code_mode);
               end
               st_next.prdata = {29'h0000_0000, st_reg.protocol_sel};
            end
            scmc_pkg::OFS_CHANNEL_CMD:
               st_next.prdata = 32'h0000_0000;
            scmc_pkg::OFS_DECODED:
               st_next.prdata = {16'h0000, st_reg.tx_char_bits, st_reg.rx_char_bits,
                                 st_reg.tx_parity, st_reg.rx_parity, st_reg.tx_char_len, st_reg.rx_char_len};
            default:
               st_next.pslverr = 1'b1;
         endcase
      end

      // channel reset command clears both mode registers, protocol selector kept
      if (chan_reset)
      begin
         st_next.async_framing_mode = scmc_pkg::RST_ASYNC_FRAMING;
         st_next.line_code_mode = scmc_pkg::RST_LINE_CODE;
      end

      // latch framing at character boundaries so a character in flight keeps its format
      if (tx_char_start)
      begin
         st_next.tx_char_len = st_reg.async_framing_mode[scmc_pkg::POS_TX_CHAR +: 2];
         st_next.tx_parity = st_reg.async_framing_mode[scmc_pkg::POS_PARITY +: 2];
      end
      if (rx_char_start)
      begin
         st_next.rx_char_len = st_reg.async_framing_mode[scmc_pkg::POS_RX_CHAR +: 2];
         st_next.rx_parity = st_reg.async_framing_mode[scmc_pkg::POS_PARITY +: 2];
      end
      st_next.tx_char_bits = char_bits(st_reg.tx_char_len);
      st_next.rx_char_bits = char_bits(st_reg.rx_char_len);
      st_next.tx_parity_sel = st_reg.tx_parity;
      st_next.rx_parity_sel = st_reg.rx_parity;

      // one oversample shared by both directions
      case (ovs_code)
         2'h0: st_next.oversample_log2 = scmc_pkg::OVS_LOG2_1;
         2'h1: st_next.oversample_log2 = scmc_pkg::OVS_LOG2_16;
         2'h2: st_next.oversample_log2 = scmc_pkg::OVS_LOG2_32;
         default: st_next.oversample_log2 = scmc_pkg::OVS_LOG2_64;
      endcase
      if (in_sync_mode)
         st_next.oversample_log2 = scmc_pkg::OVS_LOG2_1;
      // only meaningful in bit-sync, zero elsewhere
      st_next.frame_addr_check_sel = (st_reg.protocol_sel == scmc_pkg::PROTO_BITSYNC) ? ovs_code : 2'h0;

      fam_var = {st_reg.line_code_mode[scmc_pkg::POS_FAMILY], st_reg.line_code_mode[scmc_pkg::POS_VARIANT +: 2]};
      case (fam_var)
         3'b000: st_next.line_code = scmc_pkg::SCMC_CODE_NRZ;
         3'b001: st_next.line_code = scmc_pkg::SCMC_CODE_NRZI;
         3'b100: st_next.line_code = scmc_pkg::SCMC_CODE_MANCH;
         3'b101: st_next.line_code = scmc_pkg::SCMC_CODE_FM1;
         3'b110: st_next.line_code = scmc_pkg::SCMC_CODE_FM0;
         default: st_next.line_code = scmc_pkg::SCMC_CODE_RSVD;
      endcase

      // reserved code and async give zero ratio
      case (st_reg.line_code_mode[scmc_pkg::POS_PLL_RATIO +: 2])
         2'h0: st_next.pll_clock_ratio = scmc_pkg::PLL_X8;
         2'h1: st_next.pll_clock_ratio = scmc_pkg::PLL_X16;
         2'h2: st_next.pll_clock_ratio = scmc_pkg::PLL_X32;
         default: st_next.pll_clock_ratio = 6'h00;
      endcase
      if (!in_sync_mode)
         st_next.pll_clock_ratio = 6'h00;

      // receive clock through the pll path when rx_clock_is_pll; echo data through the pll path when noise suppression is chosen
      sel_clock = rx_clock_is_pll ? st_reg.line[2] : st_reg.line[3];
      sel_data = noise_supp_sel ? st_reg.line[1] : st_reg.line[4];
      case (conn)
         scmc_pkg::CONN_NORMAL:
         begin
            st_next.tx_enable = 1'b1;
            st_next.serial_out = st_reg.line[0];
            st_next.rx_data_out = st_reg.line[4];
            st_next.shift_clock = st_reg.line[3];
            st_next.tx_clock_line_oe = 1'b0;
         end
         scmc_pkg::CONN_ECHO:
         begin
            st_next.tx_enable = 1'b0;
            st_next.serial_out = sel_data;
            st_next.rx_data_out = sel_data;
            st_next.shift_clock = sel_clock;
            st_next.tx_clock_line_oe = tx_clock_line_is_output;
         end
         scmc_pkg::CONN_LOOP:
         begin
            st_next.tx_enable = 1'b1;
            st_next.rx_data_out = st_reg.line[0];
            st_next.serial_out = sel_data;
            st_next.shift_clock = sel_clock;
            st_next.tx_clock_line_oe = tx_clock_line_is_output;
         end
         default:
         begin
            // reserved connection: transmitter held off, serial output at mark, receive data and clock as in normal
            st_next.tx_enable = 1'b0;
            st_next.serial_out = 1'b1;
            st_next.rx_data_out = st_reg.line[4];
            st_next.shift_clock = st_reg.line[3];
            st_next.tx_clock_line_oe = 1'b0;
         end
      endcase
      st_next.tx_clock_line_out = sel_clock;
   end

   // hardware reset; all state including outputs starts from constants
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
         st_reg.async_framing_mode <= scmc_pkg::RST_ASYNC_FRAMING;
         st_reg.line_code_mode <= scmc_pkg::RST_LINE_CODE;
         st_reg.protocol_sel <= scmc_pkg::RST_PROTOCOL;
         st_reg.tx_char_bits <= scmc_pkg::CHAR_LEN_MAX;
         st_reg.rx_char_bits <= scmc_pkg::CHAR_LEN_MAX;
         st_reg.tx_enable <= 1'b1;
         st_reg.serial_out <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign oversample_log2 = st_reg.oversample_log2;
   assign frame_addr_check_sel = st_reg.frame_addr_check_sel;
   assign tx_char_bits = st_reg.tx_char_bits;
   assign rx_char_bits = st_reg.rx_char_bits;
   assign tx_parity_sel = st_reg.tx_parity_sel;
   assign rx_parity_sel = st_reg.rx_parity_sel;
   assign line_code = st_reg.line_code;
   assign pll_clock_ratio = st_reg.pll_clock_ratio;
   assign tx_enable = st_reg.tx_enable;
   assign rx_data_out = st_reg.rx_data_out;
   assign serial_out = st_reg.serial_out;
   assign shift_clock = st_reg.shift_clock;
   assign tx_clock_line_out = st_reg.tx_clock_line_out;
   assign tx_clock_line_oe = st_reg.tx_clock_line_oe;

   // channel reset clears both mode registers at the next edge
   AST_CHAN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      chan_reset |=> (st_reg.async_framing_mode == 8'h00) && (st_reg.line_code_mode == 8'h00))
      else $error("mode registers not cleared by channel reset");

   // async oversample 01 gives divide by 16 one cycle after it is stored
   AST_OVERSAMPLE_16: assert property (@(posedge pclk) disable iff (!presetn)
      (!in_sync_mode && ovs_code == 2'h1) ##1 (!in_sync_mode && ovs_code == 2'h1) |-> oversample_log2 == 3'h4)
      else $error("oversample 16 not decoded");

   // address check follows bits 7-6 only in bit-sync
   AST_ADDR_CHECK: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg.protocol_sel == 3'h4) |=> frame_addr_check_sel == $past(ovs_code))
      else $error("address check select wrong");

   sequence s_tx_len_latch;
      tx_char_start ##1 !tx_char_start;
   endsequence

   // decoded transmit length shows the latched code one cycle after it is latched, mapping 8-code
   AST_TX_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      s_tx_len_latch |=> tx_char_bits == 4'h8 - {2'h0, $past(st_reg.tx_char_len)})
      else $error("transmit length map wrong");

   // without a boundary the transmit length code holds through a register write
   AST_TX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_char_start |=> st_reg.tx_char_len == $past(st_reg.tx_char_len))
      else $error("transmit length changed mid character");

   AST_RX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !rx_char_start |=> st_reg.rx_char_len == $past(st_reg.rx_char_len))
      else $error("receive length changed mid character");

   // with no boundary for two cycles the parity selection seen by the shifter cannot move
   AST_PARITY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_char_start ##1 !tx_char_start |=> $stable(tx_parity_sel))
      else $error("parity changed mid character");

   // in async the line code register keeps its upper fields zero
   AST_ASYNC_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !in_sync_mode |-> st_reg.line_code_mode[7:2] == 6'h00)
      else $error("reserved line code bits set in async");

   // auto echo disables transmission
   AST_ECHO_TX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      conn == 2'h1 |=> !tx_enable)
      else $error("transmitter enabled in echo");

   // loopback carries transmit shifter data to the receive side
   AST_LOOP_DATA: assert property (@(posedge pclk) disable iff (!presetn)
      conn == 2'h3 |=> rx_data_out == $past(st_reg.line[0]))
      else $error("loopback data not routed");
endmodule

// ---- scmc_line_model.sv ----
// scmc_line_model: remote line equipment feeding serial data and receive clocks to the channel
// assumes pclk as time base; line clocks are derived from it by counting
`timescale 1ns/100ps
module scmc_line_model
(
   input wire logic pclk,
   output logic serial_in,
   output logic rx_clock_in,
   output logic pll_clock_in,
   output logic pll_data_in
);
   logic [4:0] cnt_reg = 5'h00;
   logic [7:0] pat_reg = 8'h5b;
   // idle line is mark until the first bit goes out; one process drives each line
   logic ser_reg = 1'b1;
   logic rxc_reg = 1'b0;
   logic pllc_reg = 1'b0;
   logic plld_reg = 1'b0;
   assign serial_in = ser_reg;
   assign rx_clock_in = rxc_reg;
   assign pll_clock_in = pllc_reg;
   assign pll_data_in = plld_reg;
   // clocks move only on multiples of 8 cycles, so a sampler 6 cycles after a rise sees stable levels
   always @(posedge pclk)
   begin
      cnt_reg <= cnt_reg + 5'h01;
      rxc_reg <= cnt_reg[3];
      pllc_reg <= cnt_reg[4];
      // new data bit just before each falling receive clock, never a fixed value
      if (cnt_reg == 5'h0f || cnt_reg == 5'h1f)
      begin
         pat_reg <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
         ser_reg <= pat_reg[0];
      end
      plld_reg <= ~ser_reg;
   end
endmodule

// ---- test_serial_channel_mode_config.sv ----
// test_serial_channel_mode_config: self-checking bench for the two mode registers over apb
// assumes scmc_pkg and scmc_line_model; the bench plays the shifters and the clock source setup
`timescale 1ns/100ps
module test_serial_channel_mode_config;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic tx_char_start = 1'b0, rx_char_start = 1'b0, tx_clock_line_is_output = 1'b0, rx_clock_is_pll = 1'b0;
   logic noise_supp_sel = 1'b0, tx_shift_out = 1'b0;
   logic [31:0] prdata, rd, v, prev;
   logic pready, pslverr, err, serial_in, rx_clock_in, pll_clock_in, pll_data_in;
   logic [2:0] oversample_log2, line_code;
   logic [1:0] frame_addr_check_sel, tx_parity_sel, rx_parity_sel;
   logic [3:0] tx_char_bits, rx_char_bits;
   logic [5:0] pll_clock_ratio;
   logic tx_enable, rx_data_out, serial_out, shift_clock, tx_clock_line_out, tx_clock_line_oe;
   logic [1:0] cv, dr;
   logic ck, dat;
   int errors = 0, checked = 0, cycles = 0, proto = 0, i;
   integer seed = 32'h4e99;

   scmc_mode_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_char_start(tx_char_start), .rx_char_start(rx_char_start),
      .tx_clock_line_is_output(tx_clock_line_is_output), .rx_clock_is_pll(rx_clock_is_pll),
      .serial_in(serial_in), .rx_clock_in(rx_clock_in), .pll_clock_in(pll_clock_in), .pll_data_in(pll_data_in),
      .noise_supp_sel(noise_supp_sel), .tx_shift_out(tx_shift_out), .oversample_log2(oversample_log2),
      .frame_addr_check_sel(frame_addr_check_sel), .tx_char_bits(tx_char_bits), .rx_char_bits(rx_char_bits),
      .tx_parity_sel(tx_parity_sel), .rx_parity_sel(rx_parity_sel), .line_code(line_code),
      .pll_clock_ratio(pll_clock_ratio), .tx_enable(tx_enable), .rx_data_out(rx_data_out),
      .serial_out(serial_out), .shift_clock(shift_clock), .tx_clock_line_out(tx_clock_line_out),
      .tx_clock_line_oe(tx_clock_line_oe));
   scmc_line_model line (.pclk(pclk), .serial_in(serial_in), .rx_clock_in(rx_clock_in),
      .pll_clock_in(pll_clock_in), .pll_data_in(pll_data_in));

   // 10 mhz system clock
   always #50 pclk = ~pclk;
   // hang guard: the whole run needs well under this many cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; entered just after a rising edge, waits for pready without assuming a latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
         errors++;
      @(posedge pclk);
   endtask

   // model of what a register keeps under each protocol
   function automatic logic [7:0] exp_reg(input int p, input logic [7:0] a, input logic [7:0] d);
      if (a == scmc_pkg::OFS_ASYNC_FRAMING)
         return (p == 0) ? d : (p == 4) ? (d & 8'hc0) : 8'h00;
      return (p == 0) ? (d & 8'h03) : (d & 8'hfb);
   endfunction

   task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d});
      apb(1'b0, a, 32'h00000000);
      chk(rd, {24'h000000, exp_reg(proto, a, d)});
   endtask

   // both shifters start a character, then the latched settings need two cycles
   task automatic pulse();
      tx_char_start <= 1'b1;
      rx_char_start <= 1'b1;
      @(posedge pclk);
      tx_char_start <= 1'b0;
      rx_char_start <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(tx_char_bits, 8);
      apb(1'b0, scmc_pkg::OFS_ASYNC_FRAMING, 32'h0);
      chk(rd, 0);
      prev = 8;
      // asynchronous mode: every code of every field, then random words
      for (i = 0; i < 8; i++)
      begin
         v = (i < 4) ? i * 32'h55 : $random(seed);
         wrrd(scmc_pkg::OFS_ASYNC_FRAMING, v[7:0]);
         chk(oversample_log2, (v[7:6] == 2'h0) ? 0 : v[7:6] + 3);
         chk(tx_char_bits, prev);
         pulse();
         chk(tx_char_bits, 8 - v[5:4]);
         chk(rx_char_bits, 8 - v[3:2]);
         chk(tx_parity_sel, v[1:0]);
         chk(rx_parity_sel, v[1:0]);
         chk(frame_addr_check_sel, 0);
         apb(1'b0, scmc_pkg::OFS_DECODED, 32'h0);
         chk(rd[15:8], {4'h8 - {2'h0, v[5:4]}, 4'h8 - {2'h0, v[3:2]}});
         prev = 8 - v[5:4];
      end
      wrrd(scmc_pkg::OFS_LINE_CODE, 8'hf8);
      chk(pll_clock_ratio, 0);
      // bit-synchronous mode: address checks, line codes and pll ratios
      proto = 4;
      apb(1'b1, scmc_pkg::OFS_PROTOCOL, 32'h4);
      for (i = 0; i < 8; i++)
      begin
         wrrd(scmc_pkg::OFS_ASYNC_FRAMING, {i[1:0], 6'h3f});
         // software keeps to defined code variants and pll ratios
         cv = i[2] ? ((i[1:0] == 2'h3) ? 2'h2 : i[1:0]) : {1'b0, i[0]};
         dr = (i[1:0] == 2'h3) ? 2'h1 : i[1:0];
         wrrd(scmc_pkg::OFS_LINE_CODE, {i[2], cv, dr, 3'h0});
         repeat (2) @(posedge pclk);
         chk(frame_addr_check_sel, i[1:0]);
         chk(line_code, i[2] ? cv + 3'h2 : cv);
         chk(pll_clock_ratio, 6'h08 << dr);
      end
      // channel reset clears the mode registers but keeps the protocol
      apb(1'b1, scmc_pkg::OFS_CHANNEL_CMD, 32'h1);
      apb(1'b0, scmc_pkg::OFS_ASYNC_FRAMING, 32'h0);
      chk(rd, 0);
      apb(1'b0, scmc_pkg::OFS_LINE_CODE, 32'h0);
      chk(rd, 0);
      apb(1'b0, scmc_pkg::OFS_PROTOCOL, 32'h0);
      chk(rd, 4);
      proto = 1;
      apb(1'b1, scmc_pkg::OFS_PROTOCOL, 32'h1);
      wrrd(scmc_pkg::OFS_ASYNC_FRAMING, 8'hff);
      apb(1'b0, 8'h14, 32'h0);
      chk(err, 1);
      chk(rd, 0);
      // connections: echo, loopback, normal, with the receive clock from the pll or the clock pin
      proto = 0;
      apb(1'b1, scmc_pkg::OFS_PROTOCOL, 32'h0);
      for (i = 0; i < 9; i++)
      begin
         v = (i < 3) ? 1 : (i < 6) ? 3 : 0;
         if (i % 3 == 0)
            apb(1'b1, scmc_pkg::OFS_LINE_CODE, v);
         // vary clock line direction, clock source and noise path within every connection
         tx_shift_out <= i[0];
         tx_clock_line_is_output <= i[0] ^ i[1];
         rx_clock_is_pll <= !i[0];
         noise_supp_sel <= i[1];
         @(posedge rx_clock_in);
         repeat (6) @(posedge pclk);
         ck = rx_clock_is_pll ? pll_clock_in : rx_clock_in;
         dat = noise_supp_sel ? pll_data_in : serial_in;
         chk(tx_enable, v != 1);
         chk(tx_clock_line_oe, (v != 0) && tx_clock_line_is_output);
         chk(tx_clock_line_out, ck);
         chk(serial_out, (v != 0) ? dat : tx_shift_out);
         chk(shift_clock, (v != 0) ? ck : rx_clock_in);
         chk(rx_data_out, (v == 3) ? tx_shift_out : (v == 1) ? dat : serial_in);
      end
      stop_test();
   end
endmodule
